// [src/mbg_pkg.sv]
package mbg_pkg;
  localparam int MBG_NCS = 4;
  localparam int MBG_NBANK = 4;
  localparam int MBG_AW = 12;
  localparam int MBG_RAW = 6;
  localparam int MBG_BANK_KB_MAX = 63;
  localparam int MBG_CLK_NS = 100;
  localparam int MBG_RAS_NS = 100;
  localparam int MBG_MUX_NS = 200;
  localparam int MBG_CAS_NS = 300;
  localparam int MBG_END_NS = 500;
  localparam logic [3:0] MBG_RAS_CYC = 4'((MBG_RAS_NS + MBG_CLK_NS - 1) / MBG_CLK_NS);
  localparam logic [3:0] MBG_MUX_CYC = 4'((MBG_MUX_NS + MBG_CLK_NS - 1) / MBG_CLK_NS);
  localparam logic [3:0] MBG_CAS_CYC = 4'((MBG_CAS_NS + MBG_CLK_NS - 1) / MBG_CLK_NS);
  localparam logic [3:0] MBG_END_CYC = 4'((MBG_END_NS + MBG_CLK_NS - 1) / MBG_CLK_NS);
  localparam logic [7:0] MBG_DATA_RST = 8'h00;
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [MBG_RAW-1:0] addr;
  } mbg_dram_t;
  typedef enum logic [1:0] {
    MBG_IDLE = 2'b00,
    MBG_ROW = 2'b01,
    MBG_COL = 2'b10
  } mbg_state_t;
endpackage

// [src/mbg_glue.sv]
`timescale 1ns/1ns
`default_nettype none
module mbg_glue #(
  parameter logic [3:0] P_RAS = mbg_pkg::MBG_RAS_CYC,
  parameter logic [3:0] P_MUX = mbg_pkg::MBG_MUX_CYC,
  parameter logic [3:0] P_CAS = mbg_pkg::MBG_CAS_CYC,
  parameter logic [3:0] P_END = mbg_pkg::MBG_END_CYC
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_cpu_read,
  input wire logic i_cpu_slot,
  input wire logic i_cycle_req,
  input wire logic i_ram_write,
  input wire logic [mbg_pkg::MBG_NCS-1:0] i_chip_sel,
  input wire logic [mbg_pkg::MBG_NCS-1:0] i_slow_cs_map,
  input wire logic [mbg_pkg::MBG_AW-1:0] i_addr,
  input wire logic [mbg_pkg::MBG_NBANK-1:0] i_bank_en,
  input wire logic [mbg_pkg::MBG_NBANK*8-1:0] i_bank_data,
  input wire logic i_rx_ready,
  output logic [7:0] o_db_out,
  output logic o_db_oe,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_refresh_ok,
  output mbg_pkg::mbg_dram_t o_dram,
  output logic o_phi
);
  import mbg_pkg::*;

  // two-flop synchronisers for the control and select pins; i_addr, i_bank_data and i_rx_ready are not synchronised
  logic [MBG_NCS*2+MBG_NBANK+4-1:0] s1_reg, s2_reg, s1_next;
  always_comb begin
    s1_next = {i_cpu_read, i_cpu_slot, i_cycle_req, i_ram_write, i_chip_sel, i_slow_cs_map,
               i_bank_en};
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s1_reg;
    end
  end
  logic rd, slot, creq, wr;
  logic [MBG_NCS-1:0] cs, slow_map;
  logic [MBG_NBANK-1:0] ben;
  assign {rd, slot, creq, wr, cs, slow_map, ben} = s2_reg;

  // page select and bus drive gating
  logic page_sel, drive;
  assign page_sel = |cs;
  assign drive = rd && page_sel;

  // bank selection: one-hot enables pick a lane; parallel banks share addr/ctl
  logic [7:0] bank_mux;
  always_comb begin
    bank_mux = 8'h00;
    for (int b = 0; b < MBG_NBANK; b++) begin
      if (ben[b]) begin
        bank_mux = bank_mux | i_bank_data[b*8 +: 8]; // one-hot assumed
      end
    end
  end

  // hold stage: follows bank data while slot and rd are high, latched on fall
  logic [7:0] hold_reg, hold_next;
  logic slot_d_reg;
  always_comb begin
    hold_next = hold_reg;
    if (slot && rd) begin
      hold_next = bank_mux;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      hold_reg <= MBG_DATA_RST;
      slot_d_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      slot_d_reg <= slot;
    end
  end

  // bus outputs from flops; enable low means high impedance
  logic [7:0] db_reg, db_next;
  logic oe_reg, oe_next;
  always_comb begin
    db_next = hold_reg;
    oe_next = drive;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      db_reg <= MBG_DATA_RST;
      oe_reg <= 1'b0;
    end else begin
      db_reg <= db_next;
      oe_reg <= oe_next;
    end
  end
  assign o_db_out = db_reg;
  assign o_db_oe = oe_reg;
  assign o_refresh_ok = !slot;

  // two-entry buffer: latched word pushed on slot fall, receiver may stall
  // a full buffer drops the word: the bus side has no way to wait
  logic [7:0] fifo_reg [2];
  logic [7:0] fifo_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;
  assign push = slot_d_reg && !slot && rd && page_sel && (cnt_reg != 2'd2);
  assign pop = o_rx_valid && i_rx_ready;
  assign o_rx_valid = cnt_reg != 2'd0;
  assign o_rx_data = fifo_reg[0];
  always_comb begin
    fifo_next = fifo_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      fifo_next[0] = fifo_reg[1];
      cnt_next = cnt_next - 2'd1;
    end
    if (push) begin
      fifo_next[(pop ? cnt_reg - 2'd1 : cnt_reg) == 2'd0 ? 0 : 1] = hold_reg;
      cnt_next = cnt_next + 2'd1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      fifo_reg[0] <= MBG_DATA_RST;
      fifo_reg[1] <= MBG_DATA_RST;
      cnt_reg <= 2'd0;
    end else begin
      fifo_reg <= fifo_next;
      cnt_reg <= cnt_next;
    end
  end

  // dram sequencer timed from the cycle request edge
  // pulses during a running access are ignored: one access at a time
  mbg_state_t st_reg, st_next;
  logic [3:0] tm_reg, tm_next;
  logic creq_d_reg;
  mbg_dram_t dr_reg, dr_next;
  logic creq_rise;
  assign creq_rise = creq && !creq_d_reg;
  always_comb begin
    st_next = st_reg;
    tm_next = tm_reg + 4'd1;
    dr_next = dr_reg;
    dr_next.we_n = !wr;
    case (st_reg)
      MBG_IDLE: begin
        tm_next = 4'd0;
        dr_next.ras_n = 1'b1;
        dr_next.cas_n = 1'b1;
        dr_next.addr = i_addr[MBG_RAW-1:0];
        if (creq_rise) begin
          st_next = MBG_ROW;
        end
      end
      MBG_ROW: begin
        if (tm_reg >= P_RAS) begin
          dr_next.ras_n = 1'b0;
        end
        if (tm_reg >= P_MUX) begin
          dr_next.addr = i_addr[MBG_AW-1:MBG_RAW];
          st_next = MBG_COL;
        end
      end
      MBG_COL: begin
        if (tm_reg >= P_CAS) begin
          dr_next.cas_n = 1'b0;
        end
        if (tm_reg >= P_END) begin
          st_next = MBG_IDLE;
        end
      end
      default: st_next = MBG_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      st_reg <= MBG_IDLE;
      tm_reg <= 4'd0;
      creq_d_reg <= 1'b0;
      dr_reg <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: '0};
    end else begin
      st_reg <= st_next;
      tm_reg <= tm_next;
      creq_d_reg <= creq;
      dr_reg <= dr_next;
    end
  end
  assign o_dram = dr_reg;

  // clock: phi toggles each enable; slow mode halves enables (doubled period)
  // mode taken only as a high phase ends, so no phase is cut short
  logic slow;
  assign slow = |(cs & slow_map);
  logic [1:0] div_reg, div_next;
  logic phi_reg, phi_next, slow_reg, slow_next;
  always_comb begin
    div_next = div_reg + 2'd1;
    phi_next = phi_reg;
    slow_next = slow_reg;
    if (!slow_reg || div_reg[0]) begin
      phi_next = !phi_reg;
      div_next = 2'd0;
      if (phi_reg) begin
        slow_next = slow;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      div_reg <= 2'd0;
      phi_reg <= 1'b0;
      slow_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      phi_reg <= phi_next;
      slow_reg <= slow_next;
    end
  end
  assign o_phi = phi_reg;

  property p_oe;
    @(posedge i_mclk) disable iff (!i_resetn) drive |=> o_db_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("bus not driven");
  property p_hiz;
    @(posedge i_mclk) disable iff (!i_resetn) !drive |=> !o_db_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("bus not released");
  property p_hold;
    @(posedge i_mclk) disable iff (!i_resetn) !slot |=> $stable(hold_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("held data moved");
  sequence s_start;
    st_reg == MBG_IDLE && creq_rise;
  endsequence
  property p_ras;
    @(posedge i_mclk) disable iff (!i_resetn) s_start |-> ##[1:8] !o_dram.ras_n;
  endproperty
  a_ras: assert property (p_ras) else $error("row strobe late");
  property p_we;
    @(posedge i_mclk) disable iff (!i_resetn) wr |=> !o_dram.we_n;
  endproperty
  a_we: assert property (p_we) else $error("write not routed");
  property p_page;
    @(posedge i_mclk) disable iff (!i_resetn) (cs == '0) |=> !o_db_oe;
  endproperty
  a_page: assert property (p_page) else $error("no page but driven");
  property p_fast;
    @(posedge i_mclk) disable iff (!i_resetn) !slow_reg && $changed(phi_reg) |=> $changed(phi_reg);
  endproperty
  a_fast: assert property (p_fast) else $error("fast phase wrong");
  property p_slow;
    @(posedge i_mclk) disable iff (!i_resetn)
      slow_reg && $changed(phi_reg) |=> $stable(phi_reg) ##1 $changed(phi_reg);
  endproperty
  a_slow: assert property (p_slow) else $error("slow phase wrong");

  // slow mode may only latch as a high phase ends
  property p_mode_edge;
    @(posedge i_mclk) disable iff (!i_resetn) $changed(slow_reg) |-> $fell(phi_reg);
  endproperty
  a_mode_edge: assert property (p_mode_edge) else $error("mode changed mid phase");

  // open window passes bank data to the hold node next cycle
  property p_flow;
    @(posedge i_mclk) disable iff (!i_resetn) slot && rd |=> hold_reg == $past(bank_mux);
  endproperty
  a_flow: assert property (p_flow) else $error("hold node not following");

  // window close with an empty buffer: latched word appears at the head
  sequence s_close;
    slot_d_reg && !slot;
  endsequence
  property p_push;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_close ##0 (rd && page_sel && cnt_reg == 2'd0)
      |=> o_rx_valid && o_rx_data == $past(hold_reg);
  endproperty
  a_push: assert property (p_push) else $error("latched word lost");

  // a stalled receiver keeps seeing the same head word
  property p_stall;
    @(posedge i_mclk) disable iff (!i_resetn)
      o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data);
  endproperty
  a_stall: assert property (p_stall) else $error("head word moved in stall");

  // column strobe only inside a row strobe
  property p_cas;
    @(posedge i_mclk) disable iff (!i_resetn) !o_dram.cas_n |-> !o_dram.ras_n;
  endproperty
  a_cas: assert property (p_cas) else $error("column strobe without row");

  // every started access runs through the row state and back to idle
  sequence s_run;
    (st_reg == MBG_ROW) ##[1:8] (st_reg == MBG_IDLE);
  endsequence
  property p_run;
    @(posedge i_mclk) disable iff (!i_resetn) s_start |=> s_run;
  endproperty
  a_run: assert property (p_run) else $error("access did not finish");
endmodule // mbg_glue
`default_nettype wire

// [sim/mbg_ram_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mbg_ram_model (
  input wire mbg_pkg::mbg_dram_t i_dram,
  input wire logic [7:0] i_seed,
  output logic [mbg_pkg::MBG_NBANK*8-1:0] o_bank_data,
  output logic [mbg_pkg::MBG_AW-1:0] o_addr_seen
);
  import mbg_pkg::*;
  // every bank sees the same strobes, so all answer at once; glue picks one
  for (genvar b = 0; b < MBG_NBANK; b++) begin : g_bank
    assign o_bank_data[8*b+:8] = i_seed ^ 8'(b * 17);
  end
  // one driver per half, joined into the seen address
  logic [MBG_RAW-1:0] row_seen, col_seen;
  assign o_addr_seen = {col_seen, row_seen};
  // row half taken on row strobe fall; settle delay avoids an edge race
  always @(negedge i_dram.ras_n) begin
    #1 row_seen = i_dram.addr;
  end
  // column half taken on column strobe fall
  always @(negedge i_dram.cas_n) begin
    #1 col_seen = i_dram.addr;
  end
endmodule // mbg_ram_model
`default_nettype wire

// [sim/test_memory_bus_glue.sv]
`timescale 1ns/1ns
`default_nettype none
module test_memory_bus_glue;
  import mbg_pkg::*;
  localparam logic [9:0] ROWS [5] = '{10'h022, 10'h202, 10'h245, 10'h309, 10'h231};
  logic i_mclk = 0, i_resetn = 0, rd = 0, slot = 0, req = 0, wr = 0, rdy = 0;
  logic [3:0] cs = 4'h0, smap = 4'h0, ben = 4'h1;
  logic [11:0] addr = 12'h000;
  logic [7:0] seed = 8'h3c, per;
  logic we_low;
  int error_cnt = 0, tests_run = 0, k;
  wire logic [31:0] bdata;
  wire logic [11:0] seen;
  wire logic [7:0] db, rxd;
  wire logic oe, rxv, rok, phi;
  mbg_dram_t dram;
  mbg_glue dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cpu_read(rd), .i_cpu_slot(slot),
    .i_cycle_req(req), .i_ram_write(wr), .i_chip_sel(cs), .i_slow_cs_map(smap),
    .i_addr(addr), .i_bank_en(ben), .i_bank_data(bdata), .i_rx_ready(rdy), .o_db_out(db),
    .o_db_oe(oe), .o_rx_valid(rxv), .o_rx_data(rxd), .o_refresh_ok(rok), .o_dram(dram),
    .o_phi(phi));
  mbg_ram_model ram_u (.i_dram(dram), .i_seed(seed), .o_bank_data(bdata), .o_addr_seen(seen));
  // 100 ns clock
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  // inputs move a fixed 10 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask
  task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bus byte from the enabled banks
  function automatic logic [7:0] exp_db(input logic [3:0] en, input logic [7:0] s);
    exp_db = 8'h00;
    for (int b = 0; b < 4; b++) if (en[b]) exp_db |= s ^ 8'(b * 17);
  endfunction
  // one read in the first half, then the window closes and the word is held
  task automatic push(input logic [7:0] s);
    seed = s;
    slot = 1;
    tick(4);
    slot = 0;
    tick(4);
  endtask
  // cycles between two rising edges of the divided clock
  task automatic phi_period(output logic [7:0] p);
    logic prev;
    int j, r1;
    r1 = -1;
    p = 8'h00;
    prev = phi;
    for (j = 0; j < 40; j++) begin
      tick(1);
      if (phi && !prev) begin
        if (r1 >= 0 && p == 0) p = 8'(j - r1);
        r1 = j;
      end
      prev = phi;
    end
  endtask
  initial begin
    #100_000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    tick(5);
    chk({oe, rxv, dram.ras_n, dram.cas_n, phi}, 16'h0006);
    i_resetn = 1;
    slot = 1;
    // table: read, chip selects, bank enables -> bus drive
    foreach (ROWS[i]) begin
      {rd, cs, ben} = ROWS[i][9:1];
      tick(4);
      chk(oe, ROWS[i][0]);
      chk(rok, 0);
      if (ROWS[i][0]) chk(db, exp_db(ben, seed));
    end
    // held word survives a change of RAM data in the second half
    ben = 4'h1;
    cs = 4'h1;
    push(8'h5a);
    seed = 8'ha5;
    tick(3);
    chk(db, 16'h005a);
    chk(rok, 1);
    // three words into a two-entry buffer while the receiver stalls
    push(8'h66);
    push(8'h77);
    chk({rxv, rxd}, 16'h015a);
    rdy = 1;
    tick(1);
    rdy = 0;
    chk({rxv, rxd}, 16'h0166);
    rdy = 1;
    tick(1);
    rdy = 0;
    tick(1);
    chk(rxv, 0);
    // dram sequence with a write pending
    rd = 0;
    addr = 12'ha5c;
    wr = 1;
    req = 1;
    we_low = 0;
    tick(1);
    req = 0;
    for (k = 0; k < 12 && dram.cas_n; k++) begin
      tick(1);
      if (!dram.we_n) we_low = 1;
    end
    chk(dram.ras_n, 0);
    chk(we_low, 1);
    tick(6);
    wr = 0;
    chk(seen, 16'h0a5c);
    // clock period, fast then slow
    phi_period(per);
    chk(per, 2);
    smap = 4'h1;
    tick(8);
    phi_period(per);
    chk(per, 4);
    // reset mid-run clears the held word, the strobes and the clock
    i_resetn = 0;
    tick(2);
    chk({db, oe, rxv, dram.ras_n, dram.cas_n, phi}, 16'h0006);
    i_resetn = 1;
    tick(2);
    tally_and_finish();
  end
endmodule // test_memory_bus_glue
`default_nettype wire
